//--- hw/iio_pkg.sv
package iio_pkg;

   localparam int unsigned IIO_NPTS     = 64;
   localparam int unsigned IIO_AW       = 6;
   localparam int unsigned IIO_ACC_W    = 32;
   localparam int unsigned IIO_CNT_W    = 6;
   localparam logic        IIO_RUNG_RST = 1'b0;
   localparam logic        IIO_DONE_RST = 1'b0;

   typedef enum logic [3:0] {
      IIO_LIVE_STORE             = 4'h0,
      IIO_LIVE_STORE_INVERTED    = 4'h1,
      IIO_LIVE_PARALLEL          = 4'h2,
      IIO_LIVE_PARALLEL_INVERTED = 4'h3,
      IIO_LIVE_SERIES            = 4'h4,
      IIO_LIVE_SERIES_INVERTED   = 4'h5,
      IIO_LIVE_OUTPUT            = 4'h6,
      IIO_LIVE_OR_OUTPUT         = 4'h7,
      IIO_LIVE_FORMATTED_OUTPUT  = 4'h8,
      IIO_LIVE_SET               = 4'h9,
      IIO_LIVE_RESET             = 4'hA
   } iio_op_e;

   // One instruction as issued by the sequencer.
   typedef struct packed {
      iio_op_e               op;
      logic [IIO_AW-1:0]     addr;
      logic [IIO_AW-1:0]     addr_last;
      logic [IIO_CNT_W-1:0]  count;
   } iio_instr_s;

endpackage

//--- hw/iio_unit.sv
`timescale 1ns/1ps
`default_nettype none

module iio_unit #(
   parameter int unsigned NPTS = iio_pkg::IIO_NPTS
) (
   input  wire logic                              clk,
   input  wire logic                              sys_rst,
   input  wire logic                              scan_start,
   input  wire logic                              instr_valid,
   input  wire iio_pkg::iio_instr_s               instr,
   input  wire logic [iio_pkg::IIO_ACC_W-1:0]     acc,
   input  wire logic [NPTS-1:0]                   in_pins,
   output logic                                   instr_done,
   output logic                                   rung,
   output logic [NPTS-1:0]                        out_pins,
   output logic [NPTS-1:0]                        out_image
);
   import iio_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [NPTS-1:0] in_s1;
      logic [NPTS-1:0] in_s2;
      logic            rung;
      logic            done;
      logic [NPTS-1:0] out_pins;
      logic [NPTS-1:0] out_image;
      logic [NPTS-1:0] or_seen;
   } iio_state_s;

   iio_state_s           st_reg;
   iio_state_s           st_next;
   logic                 samp_bit;
   logic [IIO_ACC_W-1:0] acc_masked;
   logic [NPTS-1:0]      fmt_mask;
   logic [NPTS-1:0]      fmt_val;
   logic [NPTS-1:0]      rng_mask;

   // Live reads take the point from the second synchroniser stage only, so a pin
   // that moves near the edge reaches a live read only after two clock edges; each instruction reads it afresh.
   assign samp_bit = st_reg.in_s2[instr.addr];

   // ----------------------------------------------------------------
   // Per-point field and range selection
   // ----------------------------------------------------------------
   always_comb begin
      for (int unsigned b = 0; b < IIO_ACC_W; b++) begin
         acc_masked[b] = acc[b] & (b < 32'(instr.count));
      end
   end

   generate
      for (genvar i = 0; i < NPTS; i++) begin : g_pt
         localparam logic [IIO_AW-1:0] PI = IIO_AW'(i);
         logic [IIO_AW-1:0] off;
         // The offset wraps for points below the first one; the PI >= addr term masks those out.
         assign off         = PI - instr.addr;
         assign fmt_mask[i] = (PI >= instr.addr) && (32'(off) < 32'(instr.count));
         assign fmt_val[i]  = (32'(off) < IIO_ACC_W) ? acc_masked[off[4:0]] : 1'b0;
         assign rng_mask[i] = (PI >= instr.addr) && (PI <= instr.addr_last);
      end
   endgenerate

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_next       = st_reg;
      st_next.in_s1 = in_pins;
      st_next.in_s2 = st_reg.in_s1;
      st_next.done  = 1'b0;
      // A new scan forgets which points an OR-output has already written.
      if (scan_start) begin
         st_next.or_seen = '0;
      end
      if (instr_valid) begin
         st_next.done = 1'b1;
         unique case (instr.op)
            IIO_LIVE_STORE:            st_next.rung = samp_bit;
            IIO_LIVE_STORE_INVERTED:   st_next.rung = ~samp_bit;
            IIO_LIVE_PARALLEL:         st_next.rung = st_reg.rung | samp_bit;
            IIO_LIVE_PARALLEL_INVERTED: st_next.rung = st_reg.rung | ~samp_bit;
            IIO_LIVE_SERIES:           st_next.rung = st_reg.rung & samp_bit;
            IIO_LIVE_SERIES_INVERTED:  st_next.rung = st_reg.rung & ~samp_bit;
            IIO_LIVE_OUTPUT: begin
               st_next.out_pins[instr.addr]  = st_reg.rung;
               st_next.out_image[instr.addr] = st_reg.rung;
            end
            IIO_LIVE_OR_OUTPUT: begin
               if (st_reg.or_seen[instr.addr] && !scan_start) begin
                  st_next.out_pins[instr.addr]  = st_reg.out_pins[instr.addr] | st_reg.rung;
                  st_next.out_image[instr.addr] = st_reg.out_image[instr.addr] | st_reg.rung;
               end else begin
                  st_next.out_pins[instr.addr]  = st_reg.rung;
                  st_next.out_image[instr.addr] = st_reg.rung;
               end
               st_next.or_seen[instr.addr] = 1'b1;
            end
            IIO_LIVE_FORMATTED_OUTPUT: begin
               st_next.out_pins  = (st_reg.out_pins & ~fmt_mask) | (fmt_val & fmt_mask);
               st_next.out_image = (st_reg.out_image & ~fmt_mask) | (fmt_val & fmt_mask);
            end
            IIO_LIVE_SET: begin
               st_next.out_pins  = st_reg.out_pins | rng_mask;
               st_next.out_image = st_reg.out_image | rng_mask;
            end
            IIO_LIVE_RESET: begin
               st_next.out_pins  = st_reg.out_pins & ~rng_mask;
               st_next.out_image = st_reg.out_image & ~rng_mask;
            end
            default: st_next.done = 1'b1;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_reg           <= '0;
         st_reg.rung      <= IIO_RUNG_RST;
         st_reg.done      <= IIO_DONE_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   assign instr_done = st_reg.done;
   assign rung       = st_reg.rung;
   assign out_pins   = st_reg.out_pins;
   assign out_image  = st_reg.out_image;

   // ----------------------------------------------------------------
   // Checks: rung evaluation
   // ----------------------------------------------------------------
   store_value_a: assert property (@(posedge clk) disable iff (sys_rst)
      instr_valid && instr.op == IIO_LIVE_STORE |=> rung == $past(samp_bit))
      else $error("live store rung differs from sampled input");
   store_inv_a: assert property (@(posedge clk) disable iff (sys_rst)
      instr_valid && instr.op == IIO_LIVE_STORE_INVERTED |=> rung != $past(samp_bit))
      else $error("live store inverted rung not inverse of input");
   parallel_or_a: assert property (@(posedge clk) disable iff (sys_rst)
      instr_valid && instr.op == IIO_LIVE_PARALLEL |=> rung == ($past(rung) | $past(samp_bit)))
      else $error("live parallel result wrong");
   parallel_inv_a: assert property (@(posedge clk) disable iff (sys_rst)
      instr_valid && instr.op == IIO_LIVE_PARALLEL_INVERTED && !samp_bit |=> rung)
      else $error("live parallel inverted failed to set rung");
   series_and_a: assert property (@(posedge clk) disable iff (sys_rst)
      instr_valid && instr.op == IIO_LIVE_SERIES && !samp_bit |=> !rung)
      else $error("live series failed to clear rung");
   series_inv_a: assert property (@(posedge clk) disable iff (sys_rst)
      instr_valid && instr.op == IIO_LIVE_SERIES_INVERTED |=> rung == ($past(rung) & ~$past(samp_bit)))
      else $error("live series inverted result wrong");

   // ----------------------------------------------------------------
   // Checks: output writes
   // ----------------------------------------------------------------
   output_both_a: assert property (@(posedge clk) disable iff (sys_rst)
      instr_valid && instr.op == IIO_LIVE_OUTPUT
      |=> out_pins[$past(instr.addr)] == $past(rung) && out_image[$past(instr.addr)] == $past(rung))
      else $error("live output not written to module and image");
   output_repeat_a: assert property (@(posedge clk) disable iff (sys_rst)
      instr_valid && instr.op == IIO_LIVE_OUTPUT && out_pins[instr.addr] != rung
      |=> out_pins[$past(instr.addr)] != $past(out_pins[instr.addr]))
      else $error("live output did not move the module point at once");
   or_output_a: assert property (@(posedge clk) disable iff (sys_rst)
      instr_valid && instr.op == IIO_LIVE_OR_OUTPUT && rung |=> out_pins[$past(instr.addr)])
      else $error("live or-output with true rung left point off");
   or_first_a: assert property (@(posedge clk) disable iff (sys_rst)
      instr_valid && instr.op == IIO_LIVE_OR_OUTPUT && scan_start
      |=> out_pins[$past(instr.addr)] == $past(rung) && out_image[$past(instr.addr)] == $past(rung))
      else $error("first live or-output of a scan did not take the rung");
   fmt_first_a: assert property (@(posedge clk) disable iff (sys_rst)
      instr_valid && instr.op == IIO_LIVE_FORMATTED_OUTPUT && instr.count != '0
      |=> out_pins[$past(instr.addr)] == $past(acc[0]))
      else $error("live formatted output first point differs from accumulator bit 0");
   fmt_outside_a: assert property (@(posedge clk) disable iff (sys_rst)
      instr_valid && instr.op == IIO_LIVE_FORMATTED_OUTPUT && instr.count == 6'h01
      && instr.addr != 6'h3f
      |=> out_pins[$past(instr.addr) + 6'h01] == $past(out_pins[instr.addr + 6'h01]))
      else $error("live formatted output wrote past its field");
   set_range_a: assert property (@(posedge clk) disable iff (sys_rst)
      instr_valid && instr.op == IIO_LIVE_SET |=> (out_pins & $past(rng_mask)) == $past(rng_mask))
      else $error("live set left a point off");
   // Idle cycles and rung-only instructions leave every written point where it stands.
   set_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      !instr_valid || instr.op < IIO_LIVE_OUTPUT
      |=> out_pins == $past(out_pins) && out_image == $past(out_image))
      else $error("outputs moved without an output instruction");
   reset_range_a: assert property (@(posedge clk) disable iff (sys_rst)
      instr_valid && instr.op == IIO_LIVE_RESET |=> (out_image & $past(rng_mask)) == '0)
      else $error("live reset left a point on");

   // ----------------------------------------------------------------
   // Checks: sequencing
   // ----------------------------------------------------------------
   done_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
      instr_valid |=> instr_done)
      else $error("instruction not completed in one cycle");
   done_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
      !instr_valid |=> !instr_done)
      else $error("completion pulse without an instruction");

endmodule

`default_nettype wire

//--- test/iio_io_model.sv
`timescale 1ns/1ps
`default_nettype none

module iio_io_model (
   input  wire logic        clk,
   input  wire logic        load,
   input  wire logic [63:0] pat,
   output logic [63:0]      in_pins
);
   // Input points change only on a load, so a pattern is stable while it is sampled.
   initial in_pins = 64'h0000_0000_0000_0000;
   always @(posedge clk) begin
      if (load) begin
         in_pins <= pat;
      end
   end
endmodule

`default_nettype wire

//--- test/iio_unit_test.sv
`timescale 1ns/1ps
`default_nettype none

module iio_unit_test;
   import iio_pkg::*;
   logic        clk, sys_rst, scan_start, instr_valid, instr_done, rung, load, e_rung;
   iio_instr_s  instr;
   logic [31:0] acc;
   logic [63:0] in_pins, out_pins, out_image, pat, e_out, seen_or;
   int          mismatches, n_tests, cyc, seed;

   iio_unit #(.NPTS(64)) dut (.clk(clk), .sys_rst(sys_rst), .scan_start(scan_start), .instr_valid(instr_valid),
      .instr(instr), .acc(acc), .in_pins(in_pins), .instr_done(instr_done), .rung(rung), .out_pins(out_pins),
      .out_image(out_image));
   iio_io_model io (.clk(clk), .load(load), .pat(pat), .in_pins(in_pins));

   always #25 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         test_done();
      end
   end

   task test_done;
      if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task chk(input logic [63:0] s, input logic [63:0] e);
      n_tests++;
      if (s !== e) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask

   function automatic void predict(iio_instr_s i, logic ss);
      logic p;
      p = pat[i.addr];
      if (ss) seen_or = '0;
      case (i.op)
         IIO_LIVE_STORE:            e_rung = p;
         IIO_LIVE_STORE_INVERTED:   e_rung = ~p;
         IIO_LIVE_PARALLEL:         e_rung = e_rung | p;
         IIO_LIVE_PARALLEL_INVERTED: e_rung = e_rung | ~p;
         IIO_LIVE_SERIES:           e_rung = e_rung & p;
         IIO_LIVE_SERIES_INVERTED:  e_rung = e_rung & ~p;
         IIO_LIVE_OUTPUT:           e_out[i.addr] = e_rung;
         IIO_LIVE_OR_OUTPUT: begin
            e_out[i.addr] = seen_or[i.addr] ? (e_out[i.addr] | e_rung) : e_rung;
            seen_or[i.addr] = 1'b1;
         end
         IIO_LIVE_FORMATTED_OUTPUT: for (int k = 0; k < i.count; k++) if (i.addr + k < 64) e_out[i.addr + k] = acc[k];
         IIO_LIVE_SET, IIO_LIVE_RESET: for (int k = i.addr; k <= i.addr_last; k++) e_out[k] = (i.op == IIO_LIVE_SET);
         default: ;
      endcase
   endfunction

   task issue(input iio_op_e op, input int a, input int l, input int c, input logic ss);
      instr.op = op;
      instr.addr = a[5:0];
      instr.addr_last = l[5:0];
      instr.count = c[5:0];
      acc = $urandom();
      instr_valid = 1'b1;
      scan_start = ss;
      predict(instr, ss);
      @(negedge clk);
      chk(64'(instr_done), 64'h0000_0000_0000_0001);
      chk(64'(rung), 64'(e_rung));
      chk(out_pins, e_out);
      chk(out_image, e_out);
   endtask

   task idle(input logic [63:0] np);
      instr_valid = 1'b0;
      scan_start = 1'b0;
      pat = np;
      load = 1'b1;
      @(negedge clk);
      chk(64'(instr_done), 64'h0000_0000_0000_0000);
      load = 1'b0;
      repeat (3) @(negedge clk);
   endtask

   initial begin
      {clk, sys_rst, scan_start, instr_valid, load, e_rung} = 6'h01 << 4;
      instr = '0;
      acc = '0;
      {pat, e_out, seen_or} = '0;
      {mismatches, n_tests, cyc} = '0;
      seed = $urandom(32'h186e);
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      chk(out_pins | out_image | 64'(rung), 64'h0000_0000_0000_0000);
      // Corner cases: full-range set, empty and partial reset, toggling output, OR-outputs, field edges.
      idle(64'hA5A5_0F0F_FFFF_0000);
      issue(IIO_LIVE_SET, 0, 63, 1, 1'b0);
      issue(IIO_LIVE_STORE_INVERTED, 0, 0, 1, 1'b0);
      issue(IIO_LIVE_RESET, 60, 5, 1, 1'b0);
      issue(IIO_LIVE_RESET, 2, 9, 1, 1'b0);
      issue(IIO_LIVE_OUTPUT, 7, 0, 1, 1'b0);
      issue(IIO_LIVE_STORE, 0, 0, 1, 1'b0);
      issue(IIO_LIVE_OUTPUT, 7, 0, 1, 1'b0);
      issue(IIO_LIVE_OR_OUTPUT, 9, 0, 1, 1'b1);
      issue(IIO_LIVE_STORE_INVERTED, 0, 0, 1, 1'b0);
      issue(IIO_LIVE_OR_OUTPUT, 9, 0, 1, 1'b0);
      issue(IIO_LIVE_STORE, 0, 0, 1, 1'b0);
      issue(IIO_LIVE_OR_OUTPUT, 9, 0, 1, 1'b0);
      issue(IIO_LIVE_FORMATTED_OUTPUT, 40, 0, 32, 1'b0);
      issue(IIO_LIVE_FORMATTED_OUTPUT, 63, 0, 1, 1'b0);
      issue(IIO_LIVE_FORMATTED_OUTPUT, 20, 0, 1, 1'b0);
      issue(iio_op_e'(4'hB), 5, 5, 1, 1'b0);
      repeat (600) begin
         if ($urandom_range(7) == 0) idle({$urandom(), $urandom()});
         issue(iio_op_e'($urandom_range(10)), $urandom_range(63), $urandom_range(63), $urandom_range(32, 1),
               $urandom_range(15) == 0);
      end
      test_done();
   end
endmodule

`default_nettype wire
